// ### rtl/zrd_cmd.sv
// Read and digest command execution with APB register access
`timescale 1ns/1ps
// Summary of operation
// - Read returns one 4-byte word or an 8-word 32-byte block.
// - Read opcode 0x02; zone bit 7 size, bits 6-2 zero, 1-0 zone.
// - Address is word address; 32-byte reads ignore low three bits.
// - Address past the end of the zone gives an error.
// - Configuration words always readable in clear, lock state ignored.
// - Reading unlocked OTP zone gives an error.
// - Locked OTP: words 0,1 fail when otp mode non-zero; else clear.
// - Unlocked data zone errors; locked uses slot configuration word.
// - Secret slot 4-byte read gives an error.
// - Secret without read encryption fails; neither flag reads clear.
// - Encrypted read XORs each byte with temporary key byte.
// - No encrypted reads of configuration or OTP zone.
// - Partial block zero padded to 32 bytes before encryption.
// - Encryption needs key valid, origin, matching slot, random seed.
// - Start initialises engine and context, takes no message bytes.
// - End takes 0-63 bytes, digest to output and temporary key.
// - Error or other command drops context and temporary key.
// - Public step appends 64-byte slot, fails unless public key.
// - Key validated only at template block index and block count.
// - Keyed start needs digest-legal slot, inits, takes no bytes.
// - Keyed end takes 0-63 bytes, reuses key, outputs and stores.
// - Mode bits 2:0 select step; bits 7-3 must be zero.
// - End steps answer 32 bytes; others one status byte.
module zrd_cmd (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic eng_req,
   output logic [2:0] eng_op,
   output logic [6:0] eng_len,
   output logic [511:0] eng_msg,
   output logic [255:0] eng_key,
   input wire logic eng_done,
   input wire logic [255:0] eng_digest,
   output logic busy,
   output logic key_validated
);
   function automatic logic [15:0] hsel(input logic [31:0] w,
                                         input logic hi);
      hsel = hi ? w[31:16] : w[15:0];
   endfunction

   logic [31:0] cfg_mem [0:zrd_pkg::CFG_WORDS-1];
   logic [31:0] otp_mem [0:zrd_pkg::OTP_WORDS-1];
   logic [31:0] dat_mem [0:zrd_pkg::DAT_WORDS-1];
   logic [31:0] msg_mem [0:zrd_pkg::MSG_WORDS-1];
   zrd_pkg::zrd_state_t state_r;
   logic [31:0] cmd_r;
   logic [6:0] len_r;
   logic [9:0] idx_r;
   logic [2:0] lock_r;
   logic [7:0] status_r;
   logic [5:0] rlen_r;
   logic done_r;
   logic [255:0] resp_r;
   logic [255:0] tk_r;
   logic tk_valid_r, tk_origin_r, tk_rand_r;
   logic [3:0] tk_key_r;
   logic ctx_r, hctx_r;
   logic [3:0] hslot_r, blk_cnt_r, pub_at_r;
   logic pub_seen_r;
   logic [1:0] pub_tmpl_r;
   logic pub_ok_r;
   logic [31:0] prdata_r;
   logic [7:0] opc, p1;
   logic [15:0] p2;
   logic [2:0] mode;
   logic apb_wr, apb_hit, go;
   logic [31:0] rd_mux;
   logic rd_err, rd_perr, rd_enc;
   logic [255:0] rd_blk;
   logic [15:0] waddr, sc, kc;
   logic [3:0] kslot;
   logic [511:0] pub_msg, upd_msg;
   logic [255:0] hkey;
   logic sha_err, sha_perr;
   logic [7:0] tmpl;

   assign opc = cmd_r[7:0];
   assign p1 = cmd_r[15:8];
   assign p2 = cmd_r[31:16];
   assign mode = p1[2:0];
   assign pready = 1'b1;
   assign apb_wr = psel & penable & pwrite;
   assign apb_hit = (paddr <= zrd_pkg::A_TKD) && (paddr[1:0] == 2'h0);
   assign pslverr = psel & penable & ~apb_hit;
   assign go = apb_wr && paddr == zrd_pkg::A_CTRL &&
               pwdata[zrd_pkg::CTRL_GO] && state_r == zrd_pkg::S_IDLE;
   assign prdata = prdata_r;
   assign busy = state_r != zrd_pkg::S_IDLE;
   assign key_validated = pub_ok_r;

   always_comb begin
      unique case (paddr)
         zrd_pkg::A_CMD: rd_mux = cmd_r;
         zrd_pkg::A_CTRL:
            rd_mux = {9'h000, len_r, 16'h0000};
         zrd_pkg::A_STAT:
            rd_mux = {12'h000, pub_ok_r, ctx_r, done_r, busy,
                      2'h0, rlen_r, status_r};
         zrd_pkg::A_LOCK: rd_mux = {29'h0, lock_r};
         zrd_pkg::A_IDX: rd_mux = {22'h0, idx_r};
         zrd_pkg::A_NVM: begin
            unique case (idx_r[9:8])
               zrd_pkg::Z_CFG: rd_mux = cfg_mem[idx_r[4:0]];
               zrd_pkg::Z_OTP: rd_mux = otp_mem[idx_r[3:0]];
               default: rd_mux = dat_mem[idx_r[7:0]];
            endcase
         end
         zrd_pkg::A_MSG: rd_mux = resp_r[32*idx_r[2:0] +: 32];
         zrd_pkg::A_TKS:
            rd_mux = {24'h0, tk_key_r, 1'b0, tk_rand_r,
                      tk_origin_r, tk_valid_r};
         zrd_pkg::A_TKD: rd_mux = tk_r[32*idx_r[2:0] +: 32];
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // Read data is set up in the setup phase so it comes from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata_r <= rd_mux;
      end
   end

   // Software loads the memories; commands never write them
   always_ff @(posedge pclk) begin
      if (apb_wr && paddr == zrd_pkg::A_NVM) begin
         unique case (idx_r[9:8])
            zrd_pkg::Z_CFG: cfg_mem[idx_r[4:0]] <= pwdata;
            zrd_pkg::Z_OTP: otp_mem[idx_r[3:0]] <= pwdata;
            default: dat_mem[idx_r[7:0]] <= pwdata;
         endcase
      end
      if (apb_wr && paddr == zrd_pkg::A_MSG) begin
         msg_mem[idx_r[3:0]] <= pwdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_r <= 32'h0000_0000;
         len_r <= 7'h00;
         idx_r <= 10'h000;
         lock_r <= 3'h0;
      end else if (apb_wr) begin
         if (paddr == zrd_pkg::A_CMD && !busy) begin
            cmd_r <= pwdata;
         end
         if (paddr == zrd_pkg::A_CTRL && !busy) begin
            len_r <= pwdata[zrd_pkg::CTRL_LEN_LSB +: 7];
         end
         if (paddr == zrd_pkg::A_IDX) begin
            idx_r <= pwdata[9:0];
         end
         if (paddr == zrd_pkg::A_LOCK) begin
            lock_r <= pwdata[2:0];
         end
      end
   end

   // Read command checks and data fetch
   always_comb begin
      rd_err = 1'b0;
      rd_enc = 1'b0;
      rd_blk = '0;
      rd_perr = (|p1[6:2]) || p1[1:0] == 2'h3;
      sc = hsel(cfg_mem[zrd_pkg::CFG_SLOT_W + {2'h0, p2[6:4]}], p2[3]);
      waddr = p1[zrd_pkg::P1_SIZE] ? {p2[15:3], 3'h0} : p2;
      for (int i = 0; i < 8; i++) begin
         if (p1[zrd_pkg::P1_SIZE] || i == 0) begin
            unique case (p1[1:0])
               zrd_pkg::Z_CFG:
                  rd_blk[32*i +: 32] = cfg_mem[waddr[4:0] | 5'(i)];
               zrd_pkg::Z_OTP:
                  rd_blk[32*i +: 32] = otp_mem[waddr[3:0] | 4'(i)];
               default:
                  rd_blk[32*i +: 32] =
                     dat_mem[{p2[6:3], p2[8], waddr[2:0] | 3'(i)}];
            endcase
         end
      end
      unique case (p1[1:0])
         zrd_pkg::Z_CFG: begin
            rd_err = |waddr[15:5];
         end
         zrd_pkg::Z_OTP: begin
            rd_err = (|waddr[15:4]) || !lock_r[zrd_pkg::LK_OTP];
            if (|cfg_mem[zrd_pkg::CFG_OTP_W][zrd_pkg::OTP_MODE_LSB +: 8] &&
                (p1[zrd_pkg::P1_SIZE] ? waddr[15:3] == 13'h0
                                      : waddr[15:1] == 15'h0)) begin
               rd_err = 1'b1;
            end
         end
         default: begin
            rd_err = (|p2[15:9]) || p2[7] || !lock_r[zrd_pkg::LK_DAT];
            if (sc[zrd_pkg::SC_SECRET] && !p1[zrd_pkg::P1_SIZE]) begin
               rd_err = 1'b1;
            end
            if (sc[zrd_pkg::SC_SECRET] && !sc[zrd_pkg::SC_ENCRD]) begin
               rd_err = 1'b1;
            end
            // Encryption is only reachable in the data zone
            rd_enc = sc[zrd_pkg::SC_ENCRD];
            if (rd_enc && !(tk_valid_r && tk_origin_r && tk_rand_r &&
                tk_key_r == sc[zrd_pkg::SC_RKEY_LSB +: 4])) begin
               rd_err = 1'b1;
            end
         end
      endcase
      if (rd_enc) begin
         rd_blk = rd_blk ^ tk_r;
      end
   end

   // Digest command checks and operand assembly
   always_comb begin
      kslot = (mode == zrd_pkg::M_HEND) ? hslot_r : p2[3:0];
      kc = hsel(cfg_mem[zrd_pkg::CFG_KEY_W + {2'h0, kslot[3:1]}], kslot[0]);
      tmpl = cfg_mem[zrd_pkg::CFG_TMPL_W][8*pub_tmpl_r +: 8];
      for (int i = 0; i < 16; i++) begin
         pub_msg[32*i +: 32] = dat_mem[{kslot, 4'(i)}];
         upd_msg[32*i +: 32] = msg_mem[i];
      end
      for (int i = 0; i < 8; i++) begin
         hkey[32*i +: 32] = dat_mem[{kslot, 4'(i)}];
      end
      sha_perr = (|p1[7:3]) || mode > zrd_pkg::M_HEND;
      sha_err = 1'b0;
      unique case (mode)
         zrd_pkg::M_START: sha_err = len_r != 7'h00;
         zrd_pkg::M_UPDATE:
            sha_err = !ctx_r || len_r != zrd_pkg::MSG_FULL;
         zrd_pkg::M_END:
            sha_err = !ctx_r || hctx_r || len_r > zrd_pkg::MSG_MAX_END;
         zrd_pkg::M_PUBLIC:
            sha_err = !ctx_r || len_r != 7'h00 || (|p2[15:4]) ||
                      kc[zrd_pkg::KC_PRIVATE] ||
                      kc[zrd_pkg::KC_TYPE_LSB +: 3] != zrd_pkg::KT_PUBLIC;
         zrd_pkg::M_HSTART:
            sha_err = len_r != 7'h00 || (|p2[15:4]) ||
                      kc[zrd_pkg::KC_PRIVATE];
         zrd_pkg::M_HEND:
            sha_err = !ctx_r || !hctx_r ||
                      len_r > zrd_pkg::MSG_MAX_END;
         default: sha_err = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= zrd_pkg::S_IDLE;
      end else begin
         unique case (state_r)
            zrd_pkg::S_IDLE:
               if (go) state_r <= zrd_pkg::S_EXEC;
            zrd_pkg::S_EXEC:
               if (opc == zrd_pkg::OP_DIGEST && !sha_perr && !sha_err)
                  state_r <= zrd_pkg::S_ENG;
               else
                  state_r <= zrd_pkg::S_IDLE;
            zrd_pkg::S_ENG:
               if (eng_done) state_r <= zrd_pkg::S_IDLE;
         endcase
      end
   end

   // Engine request is a single pulse with operands held until done
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         eng_req <= 1'b0;
         eng_op <= zrd_pkg::M_START;
         eng_len <= 7'h00;
         eng_msg <= '0;
         eng_key <= '0;
      end else begin
         eng_req <= state_r == zrd_pkg::S_EXEC &&
                    opc == zrd_pkg::OP_DIGEST && !sha_perr && !sha_err;
         if (state_r == zrd_pkg::S_EXEC) begin
            eng_op <= mode;
            eng_len <= (mode == zrd_pkg::M_PUBLIC) ? zrd_pkg::MSG_FULL
                                                   : len_r;
            eng_msg <= (mode == zrd_pkg::M_PUBLIC) ? pub_msg : upd_msg;
            eng_key <= hkey;
         end
      end
   end

   // Results, temporary key and digest context
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_r <= zrd_pkg::ST_OK;
         rlen_r <= 6'h00;
         done_r <= 1'b0;
         resp_r <= '0;
         tk_r <= '0;
         tk_valid_r <= 1'b0;
         tk_origin_r <= 1'b0;
         tk_rand_r <= 1'b0;
         tk_key_r <= 4'h0;
         ctx_r <= 1'b0;
         hctx_r <= 1'b0;
         hslot_r <= 4'h0;
         blk_cnt_r <= 4'h0;
         pub_at_r <= 4'h0;
         pub_seen_r <= 1'b0;
         pub_tmpl_r <= 2'h0;
         pub_ok_r <= 1'b0;
      end else begin
         if (apb_wr && paddr == zrd_pkg::A_TKS) begin
            tk_valid_r <= pwdata[zrd_pkg::TK_VALID];
            tk_origin_r <= pwdata[zrd_pkg::TK_ORIGIN];
            tk_rand_r <= pwdata[zrd_pkg::TK_RAND];
            tk_key_r <= pwdata[zrd_pkg::TK_KEY_LSB +: 4];
         end
         if (apb_wr && paddr == zrd_pkg::A_TKD) begin
            tk_r[32*idx_r[2:0] +: 32] <= pwdata;
         end
         if (go) begin
            done_r <= 1'b0;
         end
         if (state_r == zrd_pkg::S_EXEC) begin
            done_r <= opc != zrd_pkg::OP_DIGEST || sha_perr || sha_err;
            rlen_r <= zrd_pkg::RLEN_ST;
            status_r <= zrd_pkg::ST_EXEC;
            if (opc == zrd_pkg::OP_READ) begin
               if (rd_perr) begin
                  status_r <= zrd_pkg::ST_PARSE;
               end else if (!rd_err) begin
                  status_r <= zrd_pkg::ST_OK;
                  resp_r <= rd_blk;
                  rlen_r <= p1[zrd_pkg::P1_SIZE] ? zrd_pkg::RLEN_BLK
                                                 : zrd_pkg::RLEN_WORD;
               end
            end else if (opc == zrd_pkg::OP_DIGEST && sha_perr) begin
               status_r <= zrd_pkg::ST_PARSE;
            end else if (opc != zrd_pkg::OP_DIGEST) begin
               status_r <= zrd_pkg::ST_PARSE;
            end
            // Any command other than a good digest step kills the context
            if (opc != zrd_pkg::OP_DIGEST || sha_perr || sha_err ||
                (opc == zrd_pkg::OP_READ && (rd_perr || rd_err))) begin
               ctx_r <= 1'b0;
               hctx_r <= 1'b0;
               tk_valid_r <= 1'b0;
            end
            if (opc == zrd_pkg::OP_READ && !rd_perr && !rd_err) begin
               // A clean read is still a foreign command for the context
               tk_valid_r <= 1'b0;
            end
         end
         if (state_r == zrd_pkg::S_ENG && eng_done) begin
            done_r <= 1'b1;
            status_r <= zrd_pkg::ST_OK;
            rlen_r <= zrd_pkg::RLEN_ST;
            unique case (eng_op)
               zrd_pkg::M_START, zrd_pkg::M_HSTART: begin
                  ctx_r <= 1'b1;
                  hctx_r <= eng_op == zrd_pkg::M_HSTART;
                  hslot_r <= p2[3:0];
                  blk_cnt_r <= 4'h0;
                  pub_seen_r <= 1'b0;
                  tk_valid_r <= 1'b0;
               end
               zrd_pkg::M_UPDATE: blk_cnt_r <= blk_cnt_r + 4'h1;
               zrd_pkg::M_PUBLIC: begin
                  pub_seen_r <= 1'b1;
                  pub_at_r <= blk_cnt_r;
                  pub_tmpl_r <= kc[zrd_pkg::KC_TMPL_LSB +: 2];
                  blk_cnt_r <= blk_cnt_r + 4'h1;
               end
               default: begin
                  resp_r <= eng_digest;
                  rlen_r <= zrd_pkg::RLEN_BLK;
                  tk_r <= eng_digest;
                  tk_valid_r <= 1'b1;
                  tk_origin_r <= 1'b0;
                  tk_rand_r <= 1'b0;
                  ctx_r <= 1'b0;
                  hctx_r <= 1'b0;
                  pub_ok_r <= pub_seen_r && pub_at_r == tmpl[3:0] &&
                              blk_cnt_r == tmpl[7:4];
               end
            endcase
         end
      end
   end
endmodule

// ### rtl/zrd_pkg.sv
// Constants and types for the zone read and digest command block
package zrd_pkg;
   localparam logic [7:0] OP_READ = 8'h02;
   localparam logic [7:0] OP_DIGEST = 8'h47;
   localparam logic [7:0] ST_OK = 8'h00;
   localparam logic [7:0] ST_PARSE = 8'h03;
   localparam logic [7:0] ST_EXEC = 8'h0F;
   localparam logic [5:0] RLEN_ST = 6'h01;
   localparam logic [5:0] RLEN_WORD = 6'h04;
   localparam logic [5:0] RLEN_BLK = 6'h20;
   localparam int P1_SIZE = 7;
   localparam logic [1:0] Z_CFG = 2'h0;
   localparam logic [1:0] Z_OTP = 2'h1;
   localparam logic [1:0] Z_DAT = 2'h2;
   localparam logic [2:0] M_START = 3'h0;
   localparam logic [2:0] M_UPDATE = 3'h1;
   localparam logic [2:0] M_END = 3'h2;
   localparam logic [2:0] M_PUBLIC = 3'h3;
   localparam logic [2:0] M_HSTART = 3'h4;
   localparam logic [2:0] M_HEND = 3'h5;
   localparam logic [6:0] MSG_FULL = 7'h40;
   localparam logic [6:0] MSG_MAX_END = 7'h3F;
   localparam int CFG_WORDS = 32;
   localparam int OTP_WORDS = 16;
   localparam int DAT_WORDS = 256;
   localparam int MSG_WORDS = 16;
   // Slot configuration and key configuration fields
   localparam int SC_SECRET = 7;
   localparam int SC_ENCRD = 6;
   localparam int SC_RKEY_LSB = 0;
   localparam int KC_PRIVATE = 0;
   localparam int KC_TYPE_LSB = 2;
   localparam logic [2:0] KT_PUBLIC = 3'h4;
   localparam int KC_TMPL_LSB = 14;
   localparam logic [4:0] CFG_SLOT_W = 5'h05;
   localparam logic [4:0] CFG_KEY_W = 5'h18;
   localparam logic [4:0] CFG_OTP_W = 5'h04;
   localparam int OTP_MODE_LSB = 16;
   localparam logic [4:0] CFG_TMPL_W = 5'h17;
   // Register map, byte addresses
   localparam logic [7:0] A_CMD = 8'h00;
   localparam logic [7:0] A_CTRL = 8'h04;
   localparam logic [7:0] A_STAT = 8'h08;
   localparam logic [7:0] A_LOCK = 8'h0C;
   localparam logic [7:0] A_IDX = 8'h10;
   localparam logic [7:0] A_NVM = 8'h14;
   localparam logic [7:0] A_MSG = 8'h18;
   localparam logic [7:0] A_TKS = 8'h1C;
   localparam logic [7:0] A_TKD = 8'h20;
   localparam int CTRL_GO = 0;
   localparam int CTRL_LEN_LSB = 16;
   localparam int STAT_LEN_LSB = 8;
   localparam int STAT_BUSY = 16;
   localparam int STAT_DONE = 17;
   localparam int STAT_CTX = 18;
   localparam int STAT_PUBOK = 19;
   localparam int TK_VALID = 0;
   localparam int TK_ORIGIN = 1;
   localparam int TK_RAND = 2;
   localparam int TK_KEY_LSB = 4;
   localparam int LK_CFG = 0;
   localparam int LK_OTP = 1;
   localparam int LK_DAT = 2;
   typedef enum logic [1:0] {S_IDLE, S_EXEC, S_ENG} zrd_state_t;
endpackage

// ### tb/zrd_cmd_properties.sv
// Port-level properties of the zone read and digest command block
`timescale 1ns/1ps
module zrd_cmd_properties (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pslverr,
   input wire logic eng_req,
   input wire logic [2:0] eng_op,
   input wire logic [6:0] eng_len,
   input wire logic eng_done,
   input wire logic busy
);
   logic acc, go, bad;
   logic op_st, op_full, op_end;
   assign acc = psel && penable;
   assign go = acc && pwrite && paddr == zrd_pkg::A_CTRL && pwdata[0];
   assign bad = paddr > 8'h20 || paddr[1:0] != 2'h0;
   assign op_st = eng_op == zrd_pkg::M_START || eng_op == zrd_pkg::M_HSTART;
   assign op_full = eng_op == zrd_pkg::M_UPDATE || eng_op == zrd_pkg::M_PUBLIC;
   assign op_end = eng_op == zrd_pkg::M_END || eng_op == zrd_pkg::M_HEND;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_go_busy:
      assert property (go && !busy |=> busy)
      else $error("go while idle not taken");
   a_bad_addr:
      assert property (acc && bad |-> pslverr)
      else $error("unmapped access accepted");
   a_good_addr:
      assert property (acc && !bad |-> !pslverr)
      else $error("mapped access refused");
   a_req_pulse:
      assert property (eng_req |=> !eng_req)
      else $error("engine request too long");
   a_req_busy:
      assert property (eng_req |-> busy && $past(busy))
      else $error("engine request outside a command");
   a_op_legal:
      assert property (eng_req |-> eng_op <= zrd_pkg::M_HEND)
      else $error("illegal step code");
   a_start_empty:
      assert property (eng_req && op_st |-> eng_len == 7'h00)
      else $error("start step carries bytes");
   a_block_full:
      assert property (eng_req && op_full |-> eng_len == zrd_pkg::MSG_FULL)
      else $error("block step not 64 bytes");
   a_end_short:
      assert property (eng_req && op_end |-> eng_len <= zrd_pkg::MSG_MAX_END)
      else $error("end step too long");
   a_done_frees:
      assert property (busy && eng_done |=> !busy)
      else $error("command not finished after engine");
   a_op_held:
      assert property (eng_req |=> $stable(eng_op)[*2])
      else $error("step code changed");
endmodule

// ### tb/zrd_eng_model.sv
// Behavioural hash engine answering digest requests after a delay
`timescale 1ns/1ps
module zrd_eng_model (
   input wire logic pclk,
   input wire logic eng_req,
   input wire logic [6:0] eng_len,
   input wire logic [3:0] eng_dly,
   output logic eng_done = 1'b0,
   output logic [255:0] eng_digest
);
   logic [3:0] cnt_r = 4'h0;
   logic [255:0] res_r = '0;
   // Inverted outside done so a stale capture shows up
   assign eng_digest = eng_done ? res_r : ~res_r;
   always @(posedge pclk) begin
      eng_done <= cnt_r == 4'h1;
      if (eng_req) begin
         cnt_r <= eng_dly;
         for (int i = 0; i < 8; i++) begin
            res_r[32*i+:32] <= 32'hD16E_0000 + 32'(i << 8) + 32'(eng_len);
         end
      end else if (cnt_r != 4'h0) begin
         cnt_r <= cnt_r - 4'h1;
      end
   end
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the zone read and digest command block
`timescale 1ns/1ps
module tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic eng_req;
   logic [2:0] eng_op;
   logic [6:0] eng_len;
   logic [511:0] eng_msg;
   logic [255:0] eng_key;
   logic eng_done;
   logic [255:0] eng_digest;
   logic [3:0] eng_dly = 4'h1;
   logic busy;
   logic key_validated;
   logic [31:0] rd;
   logic err;
   int failures = 0;
   int comparisons = 0;
   always #2 pclk = ~pclk;
   zrd_cmd zrd_cmd_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .eng_req, .eng_op, .eng_len,
      .eng_msg, .eng_key, .eng_done, .eng_digest, .busy, .key_validated);
   zrd_eng_model zrd_eng_model_inst (.pclk, .eng_req, .eng_len, .eng_dly,
      .eng_done, .eng_digest);
   task automatic end_of_test;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic nvm(input logic [1:0] z, input int i, input logic [31:0] v);
      apb(1'b1, zrd_pkg::A_IDX, {22'h0, z, i[7:0]});
      apb(1'b1, zrd_pkg::A_NVM, v);
   endtask
   task automatic resp(input int i, input logic [31:0] e);
      apb(1'b1, zrd_pkg::A_IDX, 32'(i));
      apb(1'b0, zrd_pkg::A_MSG, 32'h0);
      chk(rd, e);
   endtask
   task automatic ctx(input logic e);
      apb(1'b0, zrd_pkg::A_STAT, 32'h0);
      chk({31'h0, rd[18]}, {31'h0, e});
   endtask
   // An expected status of FF accepts any error code
   task automatic run(input logic [7:0] op, input logic [7:0] p1,
         input logic [15:0] p2, input logic [6:0] n,
         input logic [7:0] est, input logic [5:0] len);
      apb(1'b1, zrd_pkg::A_CMD, {p2, p1, op});
      apb(1'b1, zrd_pkg::A_CTRL, {9'h0, n, 16'h0001});
      do apb(1'b0, zrd_pkg::A_STAT, 32'h0); while (rd[17] !== 1'b1);
      if (est == 8'hFF) chk({31'h0, rd[7:0] == 8'h00}, 32'h0);
      else chk({24'h0, rd[7:0]}, {24'h0, est});
      chk({26'h0, rd[13:8]}, {26'h0, len});
   endtask
   task automatic dg(input logic [2:0] m, input logic [15:0] p2,
         input logic [6:0] n, input logic [7:0] est, input logic [5:0] len);
      run(zrd_pkg::OP_DIGEST, {5'h0, m}, p2, n, est, len);
   endtask
   task automatic tk(input logic [2:0] f, input logic [3:0] k);
      apb(1'b1, zrd_pkg::A_TKS, {24'h0, k, 1'b0, f});
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, zrd_pkg::A_IDX, 32'(i));
         apb(1'b1, zrd_pkg::A_TKD, 32'h0F0F_0000 + i);
      end
   endtask
   initial begin
      repeat (30000) @(posedge pclk);
      failures++;
      end_of_test();
   end
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 8'h24, 32'h0);
      chk({31'h0, err}, 32'h1);
      for (int i = 0; i < 32; i++) nvm(2'h0, i, 32'hC0DE_0000 + i);
      for (int i = 0; i < 16; i++) nvm(2'h1, i, 32'h0700_0000 + i);
      for (int i = 0; i < 64; i++) nvm(2'h2, i, 32'hDA7A_0000 + i);
      nvm(2'h0, 5, 32'h0080_0000);
      nvm(2'h0, 6, 32'h0043_00C3);
      nvm(2'h0, 23, 32'h0000_0021);
      nvm(2'h0, 24, 32'h0000_0001);
      nvm(2'h0, 25, 32'h0000_0010);
      for (int i = 0; i < 16; i++) begin
         apb(1'b1, zrd_pkg::A_IDX, 32'(i));
         apb(1'b1, zrd_pkg::A_MSG, 32'h3E55_0000 + i);
      end
      rdz_cfg: begin
         run(zrd_pkg::OP_READ, 8'h00, 16'h3, 7'h0, 8'h00, 6'h04);
         resp(0, 32'hC0DE_0003);
         apb(1'b1, zrd_pkg::A_LOCK, 32'h1);
         run(zrd_pkg::OP_READ, 8'h80, 16'hB, 7'h0, 8'h00, 6'h20);
         for (int i = 0; i < 8; i++) resp(i, 32'hC0DE_0008 + i);
         run(zrd_pkg::OP_READ, 8'h00, 16'h20, 7'h0, 8'hFF, 6'h01);
         run(zrd_pkg::OP_READ, 8'h04, 16'h3, 7'h0, 8'h03, 6'h01);
         run(8'h55, 8'h00, 16'h3, 7'h0, 8'h03, 6'h01);
         tk(3'h7, 4'h3);
         run(zrd_pkg::OP_READ, 8'h00, 16'h3, 7'h0, 8'h00, 6'h04);
         resp(0, 32'hC0DE_0003);
         $display("configuration zone test done");
      end
      run(zrd_pkg::OP_READ, 8'h01, 16'h2, 7'h0, 8'hFF, 6'h01);
      apb(1'b1, zrd_pkg::A_LOCK, 32'h3);
      run(zrd_pkg::OP_READ, 8'h01, 16'h1, 7'h0, 8'hFF, 6'h01);
      run(zrd_pkg::OP_READ, 8'h01, 16'h2, 7'h0, 8'h00, 6'h04);
      resp(0, 32'h0700_0002);
      run(zrd_pkg::OP_READ, 8'h81, 16'h10, 7'h0, 8'hFF, 6'h01);
      run(zrd_pkg::OP_READ, 8'h02, 16'h0, 7'h0, 8'hFF, 6'h01);
      apb(1'b1, zrd_pkg::A_LOCK, 32'h7);
      run(zrd_pkg::OP_READ, 8'h02, 16'h2, 7'h0, 8'h00, 6'h04);
      resp(0, 32'hDA7A_0002);
      run(zrd_pkg::OP_READ, 8'h82, 16'h5, 7'h0, 8'h00, 6'h20);
      for (int i = 0; i < 8; i++) resp(i, 32'hDA7A_0000 + i);
      run(zrd_pkg::OP_READ, 8'h02, 16'h8, 7'h0, 8'hFF, 6'h01);
      run(zrd_pkg::OP_READ, 8'h82, 16'h8, 7'h0, 8'hFF, 6'h01);
      tk(3'h7, 4'h3);
      run(zrd_pkg::OP_READ, 8'h82, 16'h10, 7'h0, 8'h00, 6'h20);
      for (int i = 0; i < 8; i++) begin
         resp(i, 32'hDA7A_0020 + i ^ 32'h0F0F_0000 + i);
      end
      apb(1'b0, zrd_pkg::A_TKS, 32'h0);
      chk({31'h0, rd[0]}, 32'h0);
      for (int i = 0; i < 4; i++) begin
         tk(i < 3 ? 3'h7 ^ (3'h1 << i) : 3'h7, i < 3 ? 4'h3 : 4'h2);
         run(zrd_pkg::OP_READ, 8'h82, 16'h10, 7'h0, 8'hFF, 6'h01);
      end
      tk(3'h7, 4'h3);
      run(zrd_pkg::OP_READ, 8'h02, 16'h18, 7'h0, 8'h00, 6'h04);
      resp(0, 32'hDA7A_0030 ^ 32'h0F0F_0000);
      resp(1, 32'h0F0F_0001);
      $display("data zone test done");
      dg(zrd_pkg::M_START, 16'h0, 7'h00, 8'h00, 6'h01);
      ctx(1'b1);
      dg(zrd_pkg::M_UPDATE, 16'h0, 7'h40, 8'h00, 6'h01);
      chk(eng_msg[511:480], 32'h3E55_000F);
      eng_dly <= 4'h9;
      dg(zrd_pkg::M_END, 16'h0, 7'h03, 8'h00, 6'h20);
      for (int i = 0; i < 8; i++) begin
         resp(i, 32'hD16E_0003 + (i << 8));
         apb(1'b0, zrd_pkg::A_TKD, 32'h0);
         chk(rd, 32'hD16E_0003 + (i << 8));
      end
      dg(zrd_pkg::M_START, 16'h0, 7'h00, 8'h00, 6'h01);
      run(zrd_pkg::OP_READ, 8'h00, 16'h3, 7'h0, 8'h00, 6'h04);
      ctx(1'b0);
      dg(zrd_pkg::M_START, 16'h0, 7'h00, 8'h00, 6'h01);
      run(zrd_pkg::OP_DIGEST, 8'h08, 16'h0, 7'h0, 8'h03, 6'h01);
      ctx(1'b0);
      dg(zrd_pkg::M_HSTART, 16'h0, 7'h00, 8'hFF, 6'h01);
      dg(zrd_pkg::M_HSTART, 16'h1, 7'h00, 8'h00, 6'h01);
      chk(eng_key[31:0], 32'hDA7A_0010);
      dg(zrd_pkg::M_HEND, 16'h0, 7'h00, 8'h00, 6'h20);
      chk(eng_key[255:224], 32'hDA7A_0017);
      resp(7, 32'hD16E_0700);
      dg(zrd_pkg::M_START, 16'h0, 7'h00, 8'h00, 6'h01);
      dg(zrd_pkg::M_PUBLIC, 16'h1, 7'h00, 8'hFF, 6'h01);
      dg(zrd_pkg::M_START, 16'h0, 7'h00, 8'h00, 6'h01);
      dg(zrd_pkg::M_UPDATE, 16'h0, 7'h40, 8'h00, 6'h01);
      dg(zrd_pkg::M_PUBLIC, 16'h2, 7'h00, 8'h00, 6'h01);
      chk(eng_msg[31:0], 32'hDA7A_0020);
      dg(zrd_pkg::M_END, 16'h0, 7'h00, 8'h00, 6'h20);
      chk({31'h0, key_validated}, 32'h1);
      dg(zrd_pkg::M_START, 16'h0, 7'h00, 8'h00, 6'h01);
      dg(zrd_pkg::M_PUBLIC, 16'h2, 7'h00, 8'h00, 6'h01);
      dg(zrd_pkg::M_END, 16'h0, 7'h00, 8'h00, 6'h20);
      chk({31'h0, key_validated}, 32'h0);
      $display("digest test done");
      end_of_test();
   end
endmodule
bind zrd_cmd zrd_cmd_properties zrd_cmd_properties_inst (.pclk, .presetn,
   .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr, .eng_req, .eng_op,
   .eng_len, .eng_done, .busy);
